// ===== hdl/mdc_pkg.sv
// holds the constants, field layout and state type of the transfer engine
// assumes a 12-bit apb byte address and a 32-bit memory-side bus
package mdc_pkg;
	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int NCH = 8;
	localparam int CNT_W = 26;
	localparam int BLK_W = 11;
	localparam int AREA_MAX = 27;
	// ----------------------------------------------------------------
	// register map, byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] CH_SPAN = 12'h100;
	localparam logic [4:0] REG_SRC = 5'h00;
	localparam logic [4:0] REG_DST = 5'h04;
	localparam logic [4:0] REG_CNT = 5'h08;
	localparam logic [4:0] REG_BLK = 5'h0c;
	localparam logic [4:0] REG_CTL = 5'h10;
	localparam logic [4:0] REG_ERA = 5'h14;
	localparam logic [4:0] REG_STS = 5'h18;
	localparam logic [4:0] REG_TRG = 5'h1c;
	localparam logic [11:0] REG_STOP = 12'h100;
	localparam logic [11:0] REG_MON = 12'h104;
	// ----------------------------------------------------------------
	// control field positions
	// ----------------------------------------------------------------
	localparam int CTL_EN = 0;
	localparam int CTL_MODE = 1;
	localparam int CTL_SIZE = 3;
	localparam int CTL_SMD = 5;
	localparam int CTL_DMD = 7;
	localparam int CTL_FREE = 9;
	localparam int CTL_RSIDE = 10;
	localparam int CTL_HW = 11;
	localparam int CTL_SEL = 12;
	localparam int ERA_DST = 5;
	localparam int STS_TEND = 0;
	localparam int STS_ESC = 1;
	localparam int STS_ERR = 2;
	localparam int STS_BUSY = 3;
	// ----------------------------------------------------------------
	// encodings and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_REPEAT = 2'h1;
	localparam logic [1:0] MODE_BLOCK = 2'h2;
	localparam logic [1:0] AMD_INC = 2'h1;
	localparam logic [1:0] AMD_DEC = 2'h2;
	localparam logic [3:0] LOW_REGION = 4'h0;
	localparam logic [3:0] HIGH_REGION = 4'hf;
	localparam logic STOP_RESET = 1'b1;
	typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR} mdc_state_e;
endpackage

// ===== hdl/mdc_dma.sv
// holds the eight-channel transfer engine with its apb register file
// assumes trig_src and mem_ack come from logic on ref_clk
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module mdc_dma
	import mdc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] trig_src,
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [1:0] mem_size,
	output logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_ack,
	output logic [NCH-1:0] tend_irq,
	output logic [NCH-1:0] esc_irq,
	output logic [NCH-1:0] elink
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [31:0] src_ff [NCH];
	logic [31:0] dst_ff [NCH];
	logic [31:0] src0_ff [NCH];
	logic [31:0] dst0_ff [NCH];
	logic [CNT_W-1:0] cnt_ff [NCH];
	logic [BLK_W-1:0] blk_ff [NCH];
	logic [BLK_W-1:0] rpt_ff [NCH];
	logic [15:0] ctl_ff [NCH];
	logic [9:0] era_ff [NCH];
	logic [NCH-1:0] pend_ff, tend_ff, esc_ff, err_ff, hw_prev_ff, hw_edge;
	logic stop_ff;
	mdc_state_e st_ff;
	logic [2:0] cur_ff;
	logic [BLK_W-1:0] left_ff;
	logic [31:0] data_ff;
	logic [31:0] prdata_ff;
	logic [NCH-1:0] tend_p_ff, esc_p_ff, elink_ff;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// legal region check
	function automatic logic addr_ok(input logic [31:0] a);
		addr_ok = (a[31:28] == LOW_REGION) || (a[31:28] == HIGH_REGION);
	endfunction

	// step an address, wrapping inside an extended area; msb flags overflow
	function automatic logic [32:0] adv(input logic [31:0] a,
		input logic [1:0] md, input logic [31:0] stp, input logic [4:0] ar);
		logic [31:0] n;
		logic [31:0] m;
		logic [4:0] arc;
		n = a;
		arc = (ar > 5'(AREA_MAX)) ? 5'(AREA_MAX) : ar;
		if (md == AMD_INC) begin
			n = a + stp;
		end else if (md == AMD_DEC) begin
			n = a - stp;
		end
		m = (arc == 5'h00) ? 32'hffffffff : ((32'h1 << arc) - 32'h1);
		adv = {(arc != 5'h00) && ((n & ~m) != (a & ~m)), (a & ~m) | (n & m)};
	endfunction

	// ----------------------------------------------------------------
	// current channel decode
	// ----------------------------------------------------------------
	logic [15:0] cctl;
	logic [1:0] cmode;
	logic [31:0] stp;
	logic [32:0] s_adv, d_adv;
	logic wr_done, rd_done, abort, blk_end, rpt_end, dec, ending, start;
	logic [NCH-1:0] elig;
	logic [2:0] gnt;

	// step width follows the unit size
	always_comb begin
		cctl = ctl_ff[cur_ff];
		cmode = cctl[CTL_MODE+:2];
		stp = 32'h1 << cctl[CTL_SIZE+:2];
		s_adv = adv(src_ff[cur_ff], cctl[CTL_SMD+:2], stp,
			era_ff[cur_ff][4:0]);
		d_adv = adv(dst_ff[cur_ff], cctl[CTL_DMD+:2], stp,
			era_ff[cur_ff][ERA_DST+:5]);
	end

	assign wr_done = (st_ff == ST_WR) && mem_ack;
	assign rd_done = (st_ff == ST_RD) && mem_ack;
	// never touch reserved space
	assign abort = (st_ff == ST_RD) &&
		!(addr_ok(src_ff[cur_ff]) && addr_ok(dst_ff[cur_ff]));
	assign blk_end = (left_ff <= 11'h001);
	assign rpt_end = (cmode == MODE_REPEAT) &&
		(rpt_ff[cur_ff] + 11'h001 >= blk_ff[cur_ff]);
	// count units, or whole blocks in block mode
	assign dec = !cctl[CTL_FREE] &&
		((cmode != MODE_BLOCK) || blk_end);
	assign ending = dec && (cnt_ff[cur_ff] <= 26'h0000001);

	// eligible channels and lowest-index grant
	always_comb begin
		gnt = 3'h0;
		for (int i = NCH - 1; i >= 0; i--) begin
			elig[i] = ctl_ff[i][CTL_EN] && pend_ff[i];
			if (elig[i]) begin
				gnt = 3'(i);
			end
		end
	end
	assign start = (st_ff == ST_IDLE) && (|elig) && !stop_ff;

	// ----------------------------------------------------------------
	// hardware trigger selection
	// ----------------------------------------------------------------
	// each channel picks one request line and reacts to its rising edge
	generate
		for (genvar g = 0; g < NCH; g++) begin : g_trig
			logic sel;
			assign sel = trig_src[ctl_ff[g][CTL_SEL+:4]];
			assign hw_edge[g] = ctl_ff[g][CTL_HW] && sel &&
				!hw_prev_ff[g];
			always_ff @(posedge ref_clk) begin
				if (sys_rst) begin
					hw_prev_ff[g] <= 1'b0;
				end else begin
					hw_prev_ff[g] <= sel;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	logic setup, acc_wr, mapped;
	logic [2:0] rch;
	logic [4:0] roff;
	assign setup = psel && !penable;
	assign acc_wr = psel && penable && pwrite;
	assign rch = paddr[7:5];
	assign roff = paddr[4:0];
	assign mapped = (paddr[1:0] == 2'h0) && ((paddr < CH_SPAN) ||
		(paddr == REG_STOP) || (paddr == REG_MON));
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = prdata_ff;

	// read data is captured in the setup cycle
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			prdata_ff <= 32'h0;
		end else if (setup) begin
			prdata_ff <= 32'h0;
			if (paddr == REG_STOP) begin
				prdata_ff <= {31'h0, stop_ff};
			end else if (paddr == REG_MON) begin
				prdata_ff <= {28'h0, tend_ff[7:4] | esc_ff[7:4] | err_ff[7:4]};
			end else if (paddr < CH_SPAN) begin
				case (roff)
					REG_SRC: prdata_ff <= src_ff[rch];
					REG_DST: prdata_ff <= dst_ff[rch];
					REG_CNT: prdata_ff <= {6'h0, cnt_ff[rch]};
					REG_BLK: prdata_ff <= {21'h0, blk_ff[rch]};
					REG_CTL: prdata_ff <= {16'h0, ctl_ff[rch]};
					REG_ERA: prdata_ff <= {22'h0, era_ff[rch]};
					REG_STS: prdata_ff <= {28'h0,
						(st_ff != ST_IDLE) && (cur_ff == rch),
						err_ff[rch], esc_ff[rch], tend_ff[rch]};
					REG_TRG: prdata_ff <= {31'h0, pend_ff[rch]};
					default: prdata_ff <= 32'h0;
				endcase
			end
		end
	end

	// module stop control, halted out of reset
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			stop_ff <= STOP_RESET;
		end else if (acc_wr && (paddr == REG_STOP)) begin
			stop_ff <= pwdata[0];
		end
	end

	// ----------------------------------------------------------------
	// channel state: software writes, engine updates, flags
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < NCH; i++) begin
				src_ff[i] <= 32'h0;
				dst_ff[i] <= 32'h0;
				src0_ff[i] <= 32'h0;
				dst0_ff[i] <= 32'h0;
				cnt_ff[i] <= 26'h0;
				blk_ff[i] <= 11'h001;
				rpt_ff[i] <= 11'h000;
				ctl_ff[i] <= 16'h0;
				era_ff[i] <= 10'h0;
			end
			pend_ff <= 8'h00;
			tend_ff <= 8'h00;
			esc_ff <= 8'h00;
			err_ff <= 8'h00;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				// software side, w1c flags lose to a same-cycle set
				if (acc_wr && (paddr < CH_SPAN) && (rch == 3'(i))) begin
					case (roff)
						REG_SRC: begin
							src_ff[i] <= pwdata;
							src0_ff[i] <= pwdata;
						end
						REG_DST: begin
							dst_ff[i] <= pwdata;
							dst0_ff[i] <= pwdata;
						end
						REG_CNT: cnt_ff[i] <= pwdata[CNT_W-1:0];
						REG_BLK: begin
							blk_ff[i] <= pwdata[BLK_W-1:0];
							rpt_ff[i] <= 11'h000;
						end
						REG_CTL: ctl_ff[i] <= pwdata[15:0];
						REG_ERA: era_ff[i] <= pwdata[9:0];
						REG_STS: begin
							tend_ff[i] <= tend_ff[i] & ~pwdata[STS_TEND];
							esc_ff[i] <= esc_ff[i] & ~pwdata[STS_ESC];
							err_ff[i] <= err_ff[i] & ~pwdata[STS_ERR];
						end
						default: ;
					endcase
				end
				// requests: set wins over acceptance
				if (start && (gnt == 3'(i))) begin
					pend_ff[i] <= 1'b0;
				end
				if ((acc_wr && (paddr < CH_SPAN) && (rch == 3'(i)) &&
					(roff == REG_TRG) && pwdata[0]) || hw_edge[i]) begin
					pend_ff[i] <= 1'b1;
				end
				if (abort && (cur_ff == 3'(i))) begin
					ctl_ff[i][CTL_EN] <= 1'b0;
					err_ff[i] <= 1'b1;
				end
				// engine side, one finished unit
				if (wr_done && (cur_ff == 3'(i))) begin
					src_ff[i] <= s_adv[31:0];
					dst_ff[i] <= d_adv[31:0];
					if (dec) begin
						cnt_ff[i] <= cnt_ff[i] - 26'h0000001;
					end
					if (cmode == MODE_REPEAT) begin
						rpt_ff[i] <= rpt_end ? 11'h000 : rpt_ff[i] + 11'h001;
						if (rpt_end && !cctl[CTL_RSIDE]) begin
							src_ff[i] <= src0_ff[i];
						end
						if (rpt_end && cctl[CTL_RSIDE]) begin
							dst_ff[i] <= dst0_ff[i];
						end
					end
					if (ending) begin
						ctl_ff[i][CTL_EN] <= 1'b0;
						tend_ff[i] <= 1'b1;
					end
					if (rpt_end || s_adv[32] || d_adv[32]) begin
						esc_ff[i] <= 1'b1;
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// engine sequencer
	// ----------------------------------------------------------------
	// a block runs without re-arbitration; single units return to idle
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_ff <= ST_IDLE;
			cur_ff <= 3'h0;
			left_ff <= 11'h000;
		end else begin
			case (st_ff)
				ST_IDLE: begin
					if (start) begin
						cur_ff <= gnt;
						st_ff <= ST_RD;
						if (ctl_ff[gnt][CTL_MODE+:2] == MODE_BLOCK) begin
							left_ff <= (blk_ff[gnt] == 11'h000) ? 11'h001 :
								blk_ff[gnt];
						end else begin
							left_ff <= 11'h001;
						end
					end
				end
				ST_RD: begin
					if (abort) begin
						st_ff <= ST_IDLE;
					end else if (rd_done) begin
						st_ff <= ST_WR;
					end
				end
				ST_WR: begin
					if (wr_done) begin
						left_ff <= left_ff - 11'h001;
						st_ff <= (blk_end || ending) ? ST_IDLE : ST_RD;
					end
				end
				default: st_ff <= ST_IDLE;
			endcase
		end
	end

	// fetched unit, kept for the write
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			data_ff <= 32'h0;
		end else if (rd_done) begin
			data_ff <= mem_rdata;
		end
	end

	// one-cycle event pulses
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tend_p_ff <= 8'h00;
			esc_p_ff <= 8'h00;
			elink_ff <= 8'h00;
		end else begin
			tend_p_ff <= (wr_done && ending) ? (8'h01 << cur_ff) : 8'h00;
			esc_p_ff <= (wr_done && (rpt_end || s_adv[32] || d_adv[32])) ?
				(8'h01 << cur_ff) : 8'h00;
			elink_ff <= (wr_done && blk_end) ? (8'h01 << cur_ff) : 8'h00;
		end
	end

	// memory side drive
	assign mem_req = ((st_ff == ST_RD) && !abort) || (st_ff == ST_WR);
	assign mem_we = (st_ff == ST_WR);
	assign mem_addr = (st_ff == ST_WR) ? dst_ff[cur_ff] : src_ff[cur_ff];
	assign mem_size = cctl[CTL_SIZE+:2];
	assign mem_wdata = data_ff;
	assign tend_irq = tend_p_ff;
	assign esc_irq = esc_p_ff;
	assign elink = elink_ff;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_unit_read;
		(st_ff == ST_RD) && mem_ack;
	endsequence
	sequence s_unit_write;
		(st_ff == ST_WR) ##[0:1000] mem_ack;
	endsequence

	a_unit_order: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_unit_read |=> s_unit_write) else $error("write did not follow read");
	a_space_legal: assert property (@(posedge ref_clk) disable iff (sys_rst)
		mem_req |-> addr_ok(mem_addr)) else $error("illegal address issued");
	a_unit_width: assert property (@(posedge ref_clk) disable iff (sys_rst)
		mem_req |-> (mem_size != 2'h3)) else $error("bad unit size");
	a_grant_lowest: assert property (@(posedge ref_clk) disable iff (sys_rst)
		start |=> (($past(elig) & ((8'h01 << cur_ff) - 8'h01)) == 8'h00))
		else $error("lower channel skipped");
	a_stop_halts: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(stop_ff && (st_ff == ST_IDLE)) |=> (st_ff == ST_IDLE))
		else $error("engine left idle while stopped");
	a_end_cause: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(tend_irq != 8'h00) |-> $past(wr_done) &&
		!ctl_ff[$past(cur_ff)][CTL_EN]) else $error("end pulse without end");
	a_link_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(elink != 8'h00) |-> $past(wr_done) ##1 (elink == 8'h00))
		else $error("event link pulse wrong");
	a_count_step: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(wr_done && dec) |=> (cnt_ff[$past(cur_ff)] ==
		$past(cnt_ff[cur_ff]) - 26'h0000001)) else $error("count not stepped");
	a_block_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(wr_done && !blk_end && !ending) |=> (st_ff == ST_RD) &&
		$stable(cur_ff)) else $error("block broken up");
	a_bus_error: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(psel && penable && (paddr == 12'hffc)) |-> pslverr)
		else $error("unmapped access not flagged");
endmodule

// ===== bench/mdc_mem_model.sv
// memory and peripheral side seen by the transfer engine
// assumes mem_req and its qualifiers hold until the ack edge
`timescale 1ns/10ps
module mdc_mem_model (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [1:0] mem_size,
	input wire logic [31:0] mem_wdata,
	output logic [31:0] mem_rdata,
	output logic mem_ack,
	output logic [31:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [1:0] wr_size,
	output int wr_cnt
);
	// ----------------------------------------------------------------
	// access handling
	// ----------------------------------------------------------------
	int wait_ff;
	// answer after 0..2 idle cycles; data bus holds in those and toggles when no request waits
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			mem_ack <= 1'b0;
			mem_rdata <= 32'h0;
			wait_ff <= 0;
			wr_cnt <= 0;
		end else if (mem_req && !mem_ack) begin
			if (wait_ff == 0) begin
				mem_ack <= 1'b1;
				mem_rdata <= mem_addr ^ 32'h5a5aa5a5;
				wait_ff <= $urandom % 3;
			end else begin
				wait_ff <= wait_ff - 1;
			end
		end else begin
			// a write lands at the edge where ack is seen
			if (mem_ack && mem_req && mem_we) begin
				wr_addr <= mem_addr;
				wr_data <= mem_wdata;
				wr_size <= mem_size;
				wr_cnt <= wr_cnt + 1;
			end
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule

// ===== bench/mdc_dma_test.sv
// self-checking bench for the eight-channel transfer engine
// assumes mdc_pkg and the memory model are compiled first
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
	$display("Error at %0t: got %h expected %h", $time, a, b); end end
module mdc_dma_test;
	import mdc_pkg::*;
	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [15:0] trig_src;
	logic mem_req, mem_we, mem_ack, rerr;
	logic [31:0] mem_addr, mem_wdata, mem_rdata, m_addr, m_data;
	logic [1:0] mem_size, m_size;
	logic [NCH-1:0] tend_irq, esc_irq, elink;
	int m_cnt, checks, miscompares;
	int n_link[8], n_tend[8], n_esc[8];
	int order[$];
	mdc_dma u_mdc_dma (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.trig_src(trig_src), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack), .tend_irq(tend_irq),
		.esc_irq(esc_irq), .elink(elink));
	mdc_mem_model u_mdc_mem_model (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_size(mem_size), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.mem_ack(mem_ack), .wr_addr(m_addr), .wr_data(m_data),
		.wr_size(m_size), .wr_cnt(m_cnt));
	// ----------------------------------------------------------------
	// clock and pulse monitor
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// count per-channel pulses and keep the completion order
	always @(posedge ref_clk) begin
		for (int i = 0; i < 8; i++) begin
			if (elink[i] === 1'b1) begin
				n_link[i]++;
				order.push_back(i);
			end
			if (tend_irq[i] === 1'b1) n_tend[i]++;
			if (esc_irq[i] === 1'b1) n_esc[i]++;
		end
	end
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	function automatic logic [11:0] ra(int c, logic [4:0] r);
		return {4'h0, 3'(c), 5'h0} | {7'h0, r};
	endfunction
	function automatic logic [31:0] rnd_addr();
		logic [31:0] u;
		u = $urandom;
		return {u[31] ? HIGH_REGION : LOW_REGION, 8'h01, u[19:2], 2'b00};
	endfunction
	function automatic logic [31:0] msk(int sz);
		return (sz == 0) ? 32'hff : (sz == 1) ? 32'hffff : 32'hffffffff;
	endfunction
	function automatic logic [31:0] ctlw(logic [1:0] md, logic [1:0] sz,
		logic hw, logic [3:0] sel, logic rs);
		logic [31:0] v;
		v = 32'h1;
		v[CTL_MODE+:2] = md;
		v[CTL_SIZE+:2] = sz;
		v[CTL_SMD+:2] = AMD_INC;
		v[CTL_DMD+:2] = AMD_INC;
		v[CTL_RSIDE] = rs;
		v[CTL_HW] = hw;
		v[CTL_SEL+:4] = sel;
		return v;
	endfunction
	// one apb transfer: setup, access until pready, then one idle edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			miscompares++;
			conclude();
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic cfg(int c, logic [31:0] s, logic [31:0] d,
		logic [31:0] n, logic [31:0] b, logic [31:0] ctl);
		apb(1'b1, ra(c, REG_SRC), s);
		apb(1'b1, ra(c, REG_DST), d);
		apb(1'b1, ra(c, REG_CNT), n);
		apb(1'b1, ra(c, REG_BLK), b);
		apb(1'b1, ra(c, REG_ERA), 32'h0);
		apb(1'b1, ra(c, REG_CTL), ctl);
	endtask
	// start a channel by software or a hardware line, await its link pulse
	task automatic go(int c, bit hw, int k);
		int b, n;
		b = n_link[c];
		if (hw) begin
			trig_src[k] <= 1'b1;
			@(posedge ref_clk);
			trig_src[k] <= 1'b0;
		end else apb(1'b1, ra(c, REG_TRG), 32'h1);
		n = 0;
		while (n_link[c] == b && n < 500) begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 500) begin
			miscompares++;
			conclude();
		end
		repeat (2) @(posedge ref_clk);
	endtask
	task automatic clr();
		for (int i = 0; i < 8; i++) begin
			n_link[i] = 0;
			n_tend[i] = 0;
			n_esc[i] = 0;
		end
		order.delete();
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] s, d;
		int a, b, k, w0;
		sys_rst = 1'b1;
		{psel, penable, pwrite} = 3'b000;
		paddr = 12'h0;
		pwdata = 32'h0;
		trig_src = 16'h0;
		checks = 0;
		miscompares = 0;
		void'($urandom(32'h350c));
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		apb(1'b0, REG_STOP, 32'h0);
		`CHK(rdat, 32'h1)
		apb(1'b0, 12'h108, 32'h0);
		`CHK(rerr, 1'b1)
		apb(1'b0, 12'hffc, 32'h0);
		`CHK(rerr, 1'b1)
		// a pending start must wait for the stop to be lifted
		cfg(7, rnd_addr(), rnd_addr(), 32'h1, 32'h0, ctlw(MODE_NORMAL, 2'h2,
			1'b0, 4'h0, 1'b0));
		apb(1'b1, ra(7, REG_TRG), 32'h1);
		repeat (20) @(posedge ref_clk);
		`CHK(n_link[7], 0)
		apb(1'b1, REG_STOP, 32'h0);
		// the held request runs alone; an unused line avoids a stale re-trigger
		go(7, 1'b1, 0);
		`CHK(n_tend[7], 1)
		// normal mode on every channel, all three widths
		for (int c = 0; c < 8; c++) begin
			clr();
			s = rnd_addr();
			d = rnd_addr();
			cfg(c, s, d, 32'h2, 32'h0, ctlw(MODE_NORMAL, 2'(c % 3), 1'b0,
				4'h0, 1'b0));
			go(c, 1'b0, 0);
			`CHK(m_addr, d)
			`CHK(m_size, 2'(c % 3))
			`CHK(m_data & msk(c % 3), (s ^ 32'h5a5aa5a5) & msk(c % 3))
			apb(1'b0, ra(c, REG_SRC), 32'h0);
			`CHK(rdat, s + (32'h1 << (c % 3)))
			apb(1'b0, ra(c, REG_CNT), 32'h0);
			`CHK(rdat, 32'h1)
			`CHK(n_tend[c], 0)
			go(c, 1'b0, 0);
			`CHK(n_tend[c], 1)
			`CHK(n_link[c], 2)
		end
		// two channels pending at once: the lower one goes first
		a = $urandom % 7;
		b = a + 1 + ($urandom % (7 - a));
		apb(1'b1, REG_STOP, 32'h1);
		cfg(a, rnd_addr(), rnd_addr(), 32'h1, 32'h0, ctlw(MODE_NORMAL,
			2'h2, 1'b0, 4'h0, 1'b0));
		cfg(b, rnd_addr(), rnd_addr(), 32'h1, 32'h0, ctlw(MODE_NORMAL,
			2'h2, 1'b0, 4'h0, 1'b0));
		apb(1'b1, ra(b, REG_TRG), 32'h1);
		apb(1'b1, ra(a, REG_TRG), 32'h1);
		clr();
		apb(1'b1, REG_STOP, 32'h0);
		k = 0;
		while (order.size() < 2 && k < 500) begin
			@(posedge ref_clk);
			k++;
		end
		`CHK(order.size(), 2)
		`CHK(order[0], a)
		// block mode: four units per start, one link pulse
		clr();
		d = rnd_addr();
		w0 = m_cnt;
		cfg(3, rnd_addr(), d, 32'h1, 32'h4, ctlw(MODE_BLOCK, 2'h2, 1'b0,
			4'h0, 1'b0));
		go(3, 1'b0, 0);
		`CHK(m_cnt - w0, 4)
		`CHK(n_link[3], 1)
		`CHK(n_tend[3], 1)
		apb(1'b0, ra(3, REG_DST), 32'h0);
		`CHK(rdat, d + 32'h10)
		// repeat mode: source start comes back after two units
		clr();
		s = rnd_addr();
		cfg(1, s, rnd_addr(), 32'h5, 32'h2, ctlw(MODE_REPEAT, 2'h1, 1'b0,
			4'h0, 1'b0));
		go(1, 1'b0, 0);
		`CHK(n_esc[1], 0)
		go(1, 1'b0, 0);
		`CHK(n_esc[1], 1)
		apb(1'b0, ra(1, REG_SRC), 32'h0);
		`CHK(rdat, s)
		// extended area on the source, free run: wraps inside 8 bytes
		clr();
		s = rnd_addr() & 32'hfffffff8;
		cfg(2, s, rnd_addr(), 32'h0, 32'h0, ctlw(MODE_NORMAL, 2'h2, 1'b0,
			4'h0, 1'b0) | (32'h1 << CTL_FREE));
		apb(1'b1, ra(2, REG_ERA), 32'h3);
		go(2, 1'b0, 0);
		`CHK(n_esc[2], 0)
		apb(1'b0, ra(2, REG_SRC), 32'h0);
		`CHK(rdat, s + 32'h4)
		go(2, 1'b0, 0);
		`CHK(n_esc[2], 1)
		apb(1'b0, ra(2, REG_SRC), 32'h0);
		`CHK(rdat, s)
		`CHK(n_tend[2], 0)
		apb(1'b0, ra(2, REG_CNT), 32'h0);
		`CHK(rdat, 32'h0)
		// hardware request on a randomly selected line
		clr();
		k = $urandom % 16;
		cfg(6, rnd_addr(), rnd_addr(), 32'h1, 32'h0, ctlw(MODE_NORMAL,
			2'h0, 1'b1, 4'(k), 1'b0));
		go(6, 1'b1, k);
		`CHK(n_link[6], 1)
		// source outside both regions: refused with an error flag
		w0 = m_cnt;
		cfg(5, 32'h20000000, rnd_addr(), 32'h1, 32'h0, ctlw(MODE_NORMAL,
			2'h2, 1'b0, 4'h0, 1'b0));
		apb(1'b1, ra(5, REG_TRG), 32'h1);
		repeat (20) @(posedge ref_clk);
		`CHK(m_cnt, w0)
		apb(1'b0, ra(5, REG_STS), 32'h0);
		`CHK(rdat[STS_ERR], 1'b1)
		apb(1'b0, REG_MON, 32'h0);
		`CHK(rdat[1], 1'b1)
		conclude();
	end
endmodule
